// >>> logic/tbpio_pkg.sv
// constants for the timer b-register pin i/o control block
// assumes one 200 mhz clock, ahb-lite register access, 16-bit channel counters
// Contract
// RL1 - After reset or standby entry the pin is driven low until its i/o control is written, and hold codes leave the pin alone at a match.
// RL2 - Output code 0x01 (low bits 01) sets the pin to field bit 2 and drives it low at a match.
// RL3 - Output code 0x10 (low bits 10) sets the pin to field bit 2 and drives it high at a match.
// RL4 - Output code 0x11 (low bits 11) sets the pin to field bit 2 and inverts it at each match.
// RL5 - Capture code 1x00 captures on a rising pin edge, and field bit 2 means nothing on channels 2 and 3.
// RL6 - Capture code 1x01 captures on a falling pin edge.
// RL7 - Capture code 1x1x captures on both pin edges.
// RL8 - On channel 1 only, code 11xx captures whenever channel 0's c register matches or captures.
// RL9 - With the channel 0 buffer enable set, the d register's i/o setting gives neither capture nor compare.
// RL10 - A compare match is the cycle in which the counter equals the b register in an output mode; the code gives no match under hold codes (low bits 00).
// RL11 - A capture copies the channel counter into the b register.
package tbpio_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NUM_CH = 3;
   localparam int CNT_W = 16;
   localparam int DATA_W = 32;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFF_CH0_MODE = 8'h00;
   localparam logic [7:0] OFF_CH0_IO = 8'h04;
   localparam logic [7:0] OFF_IO_CH1 = 8'h10;
   localparam logic [7:0] OFF_GRB_CH1 = 8'h20;
   localparam logic [7:0] OFF_STATUS = 8'h30;
   localparam logic [7:0] OFF_CH_STEP = 8'h04;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int IO_FIELD_LSB = 4;
   localparam int BUFB_BIT = 4;
   localparam int STAT_PIN_OUT_LSB = 0;
   localparam int STAT_PIN_IN_LSB = 4;
   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic [3:0] IO_RESET = 4'h0;
   localparam logic [CNT_W-1:0] GRB_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
   // ----------------------------------------
   // field codes
   // ----------------------------------------
   localparam logic [1:0] OUT_HOLD = 2'h0;
   localparam logic [1:0] OUT_LOW = 2'h1;
   localparam logic [1:0] OUT_HIGH = 2'h2;
   localparam logic [1:0] OUT_TOGGLE = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : tbpio_pkg

// >>> logic/tbpio_top.sv
// b-register pin i/o control for timer channels 1 to 3, plus channel 0 d gating
// assumes counters and channel 0 c events come from logic on CLK; pins are asynchronous
`timescale 1ns/10ps
module tbpio_top (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic STANDBY,
   input wire logic [15:0] CH1_COUNT,
   input wire logic [15:0] CH2_COUNT,
   input wire logic [15:0] CH3_COUNT,
   input wire logic CH0_C_EVENT,
   input wire logic [2:0] CH_B_PIN_IN,
   output logic [2:0] CH_B_PIN_OUT,
   output logic [2:0] CH_B_PIN_OE,
   output logic [2:0] CH_B_MATCH,
   output logic [2:0] CH_B_CAPTURE,
   output logic CH0_D_COMPARE_EN,
   output logic CH0_D_CAPTURE_EN
);
   // ----------------------------------------
   // bus slave state
   // ----------------------------------------
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] wr_addr_reg, wr_addr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic ready_reg;
   logic [3:0] ch0_io_reg, ch0_io_next;
   logic bufb_reg, bufb_next;
   logic d_cmp_reg, d_cmp_next;
   logic d_cap_reg, d_cap_next;
   logic addr_ok;
   logic [15:0] count [3];
   logic [3:0] io_reg [3];
   logic [15:0] grb_reg [3];
   logic [2:0] sync1_reg, sync2_reg, prev_reg;
   logic [2:0] pin_reg, oe_reg, match_reg, cap_reg;

   assign count[0] = CH1_COUNT;
   assign count[1] = CH2_COUNT;
   assign count[2] = CH3_COUNT;
   assign addr_ok = HSEL && HREADY && (HTRANS == tbpio_pkg::HTRANS_NONSEQ);

   // ----------------------------------------
   // address phase capture and read mux
   // ----------------------------------------
   always_comb begin
      wr_pend_next = addr_ok && HWRITE;
      wr_addr_next = addr_ok ? HADDR[7:0] : wr_addr_reg;
      rdata_next = rdata_reg;
      if (addr_ok && !HWRITE) begin
         rdata_next = tbpio_pkg::RDATA_RESET;
         case (HADDR[7:0])
            tbpio_pkg::OFF_CH0_MODE: rdata_next[tbpio_pkg::BUFB_BIT] = bufb_reg;
            tbpio_pkg::OFF_CH0_IO: rdata_next[7:4] = ch0_io_reg;
            tbpio_pkg::OFF_IO_CH1: rdata_next[7:4] = io_reg[0];
            tbpio_pkg::OFF_IO_CH1 + tbpio_pkg::OFF_CH_STEP: rdata_next[7:4] = io_reg[1];
            tbpio_pkg::OFF_IO_CH1 + 8'h08: rdata_next[7:4] = io_reg[2];
            tbpio_pkg::OFF_GRB_CH1: rdata_next[15:0] = grb_reg[0];
            tbpio_pkg::OFF_GRB_CH1 + tbpio_pkg::OFF_CH_STEP: rdata_next[15:0] = grb_reg[1];
            tbpio_pkg::OFF_GRB_CH1 + 8'h08: rdata_next[15:0] = grb_reg[2];
            tbpio_pkg::OFF_STATUS: begin
               rdata_next[tbpio_pkg::STAT_PIN_OUT_LSB +: 3] = pin_reg;
               rdata_next[tbpio_pkg::STAT_PIN_IN_LSB +: 3] = sync2_reg;
            end
            default: rdata_next = tbpio_pkg::RDATA_RESET;
         endcase
      end
   end

   // ----------------------------------------
   // channel 0 d register gating
   // ----------------------------------------
   always_comb begin
      ch0_io_next = ch0_io_reg;
      bufb_next = bufb_reg;
      if (STANDBY) begin
         ch0_io_next = tbpio_pkg::IO_RESET;
      end else if (wr_pend_reg && wr_addr_reg == tbpio_pkg::OFF_CH0_IO) begin
         ch0_io_next = HWDATA[tbpio_pkg::IO_FIELD_LSB +: 4];
      end
      if (wr_pend_reg && wr_addr_reg == tbpio_pkg::OFF_CH0_MODE) begin
         bufb_next = HWDATA[tbpio_pkg::BUFB_BIT];
      end
      // RL9 buffer disables d
      d_cmp_next = !bufb_next && !ch0_io_next[3];
      d_cap_next = !bufb_next && ch0_io_next[3];
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg <= tbpio_pkg::RDATA_RESET;
         ready_reg <= 1'b0;
         ch0_io_reg <= tbpio_pkg::IO_RESET;
         bufb_reg <= 1'b0;
         d_cmp_reg <= 1'b1;
         d_cap_reg <= 1'b0;
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         prev_reg <= 3'h0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg <= rdata_next;
         ready_reg <= 1'b1;
         ch0_io_reg <= ch0_io_next;
         bufb_reg <= bufb_next;
         d_cmp_reg <= d_cmp_next;
         d_cap_reg <= d_cap_next;
         sync1_reg <= CH_B_PIN_IN;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // ----------------------------------------
   // per-channel compare and capture
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < tbpio_pkg::NUM_CH; g++) begin : gen_ch
         logic io_wr, grb_wr, is_out, match, rise, fall, edge_ev, cap_ev;
         logic [3:0] io_next;
         logic [15:0] grb_next;
         logic pin_next, oe_next;

         always_comb begin
            io_wr = wr_pend_reg && (wr_addr_reg ==
               tbpio_pkg::OFF_IO_CH1 + 8'(g * 4));
            grb_wr = wr_pend_reg && (wr_addr_reg ==
               tbpio_pkg::OFF_GRB_CH1 + 8'(g * 4));
            is_out = !io_reg[g][3];
            // RL10 equal count matches
            match = is_out && (io_reg[g][1:0] != tbpio_pkg::OUT_HOLD) &&
               (count[g] == grb_reg[g]);
            rise = sync2_reg[g] && !prev_reg[g];
            fall = !sync2_reg[g] && prev_reg[g];
            // RL7 both edges
            if (io_reg[g][1]) begin
               edge_ev = rise || fall;
            // RL6 falling edge
            end else if (io_reg[g][0]) begin
               edge_ev = fall;
            // RL5 rising edge
            end else begin
               edge_ev = rise;
            end
            // RL8 channel 1 cascade
            if (g == 0 && io_reg[g][2]) begin
               cap_ev = io_reg[g][3] && CH0_C_EVENT;
            end else begin
               cap_ev = io_reg[g][3] && edge_ev;
            end
            // RL11 counter into b
            if (cap_ev) begin
               grb_next = count[g];
            end else if (grb_wr) begin
               grb_next = HWDATA[15:0];
            end else begin
               grb_next = grb_reg[g];
            end
            io_next = io_reg[g];
            pin_next = pin_reg[g];
            if (STANDBY) begin
               // RL1 standby drives low
               io_next = tbpio_pkg::IO_RESET;
               pin_next = 1'b0;
            end else if (io_wr) begin
               io_next = HWDATA[tbpio_pkg::IO_FIELD_LSB +: 4];
               // RL2 initial level
               if (!io_next[3] && io_next[1:0] != tbpio_pkg::OUT_HOLD) begin
                  pin_next = io_next[2];
               end
            end else if (match) begin
               case (io_reg[g][1:0])
                  // RL2 low at match
                  tbpio_pkg::OUT_LOW: pin_next = 1'b0;
                  // RL3 high at match
                  tbpio_pkg::OUT_HIGH: pin_next = 1'b1;
                  // RL4 toggle at match
                  tbpio_pkg::OUT_TOGGLE: pin_next = !pin_reg[g];
                  // RL1 hold keeps level
                  default: pin_next = pin_reg[g];
               endcase
            end
            oe_next = !io_next[3];
         end

         always_ff @(posedge CLK) begin
            if (!RST_B) begin
               io_reg[g] <= tbpio_pkg::IO_RESET;
               grb_reg[g] <= tbpio_pkg::GRB_RESET;
               // RL1 low after reset
               pin_reg[g] <= 1'b0;
               oe_reg[g] <= 1'b1;
               match_reg[g] <= 1'b0;
               cap_reg[g] <= 1'b0;
            end else begin
               io_reg[g] <= io_next;
               grb_reg[g] <= grb_next;
               pin_reg[g] <= pin_next;
               oe_reg[g] <= oe_next;
               match_reg[g] <= match;
               cap_reg[g] <= cap_ev;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign HRDATA = rdata_reg;
   assign HREADYOUT = ready_reg;
   assign HRESP = 1'b0;
   assign CH_B_PIN_OUT = pin_reg;
   assign CH_B_PIN_OE = oe_reg;
   assign CH_B_MATCH = match_reg;
   assign CH_B_CAPTURE = cap_reg;
   assign CH0_D_COMPARE_EN = d_cmp_reg;
   assign CH0_D_CAPTURE_EN = d_cap_reg;
endmodule : tbpio_top

// >>> verification/tbpio_pins.sv
// pin partner: the wire outside the three b pins
// assumes device drive wins while its enable is high, else the outside source
`timescale 1ns/10ps
module tbpio_pins (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   input wire logic [2:0] ext_level,
   output logic [2:0] pin_in
);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : tbpio_pins

// >>> verification/tbpio_chk.sv
// port assertions for the b pin i/o control block
// assumes bind to tbpio_top, one clock, synchronous reset
`timescale 1ns/10ps
module tbpio_chk (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic STANDBY,
   input wire logic CH0_C_EVENT,
   input wire logic [2:0] CH_B_PIN_IN,
   input wire logic [2:0] CH_B_PIN_OUT,
   input wire logic [2:0] CH_B_PIN_OE,
   input wire logic [2:0] CH_B_MATCH,
   input wire logic [2:0] CH_B_CAPTURE,
   input wire logic CH0_D_CAPTURE_EN
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   property p_stby;
      STANDBY |=> CH_B_PIN_OUT == 3'h0;
   endproperty
   a_stby: assert property (p_stby) else $error("pin high after standby");
   property p_cause;
      $changed(CH_B_PIN_OUT[0]) |-> CH_B_MATCH[0] || $past(STANDBY)
         || $past(HSEL && HWRITE && HTRANS == 2'h2, 2);
   endproperty
   a_cause: assert property (p_cause) else $error("pin moved without cause");
   property p_moe;
      CH_B_MATCH[1] |-> CH_B_PIN_OE[1];
   endproperty
   a_moe: assert property (p_moe) else $error("match outside output mode");
   property p_coe;
      CH_B_CAPTURE[2] |-> !CH_B_PIN_OE[2];
   endproperty
   a_coe: assert property (p_coe) else $error("capture while driving");
   property p_edge;
      CH_B_CAPTURE[2] |-> $past(CH_B_PIN_IN[2], 3) != $past(CH_B_PIN_IN[2], 4);
   endproperty
   a_edge: assert property (p_edge) else $error("capture without edge");
   property p_ev;
      CH_B_CAPTURE[0] |-> $past(CH0_C_EVENT)
         || $past(CH_B_PIN_IN[0], 3) != $past(CH_B_PIN_IN[0], 4);
   endproperty
   a_ev: assert property (p_ev) else $error("ch1 capture without source");
   property p_excl;
      CH_B_CAPTURE[1] |-> !CH_B_MATCH[1];
   endproperty
   a_excl: assert property (p_excl) else $error("capture and match together");
   property p_den;
      $rose(CH0_D_CAPTURE_EN) |-> $past(HSEL && HWRITE && HTRANS == 2'h2, 2);
   endproperty
   a_den: assert property (p_den) else $error("d capture enable without write");
   c_match: cover property (CH_B_MATCH[0]);
   c_cap: cover property (CH_B_CAPTURE[2]);
   c_ev: cover property (CH_B_CAPTURE[0] && $past(CH0_C_EVENT));
endmodule : tbpio_chk
bind tbpio_top tbpio_chk i_tbpio_chk (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .STANDBY(STANDBY), .CH0_C_EVENT(CH0_C_EVENT), .CH_B_PIN_IN(CH_B_PIN_IN),
   .CH_B_PIN_OUT(CH_B_PIN_OUT), .CH_B_PIN_OE(CH_B_PIN_OE), .CH_B_MATCH(CH_B_MATCH),
   .CH_B_CAPTURE(CH_B_CAPTURE), .CH0_D_CAPTURE_EN(CH0_D_CAPTURE_EN));

// >>> verification/tb_timer_b_pin_io_control.sv
// testbench: ahb-lite master, pin partner and behavioural pin/b model
// assumes zero-wait slave and design reset held 5 cycles
`timescale 1ns/10ps
module tb_timer_b_pin_io_control;
   logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, stby = 1'b0, c_ev = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic [2:0] ext = 3'h0, pin_in, pin_out, pin_oe, match, capt;
   logic [15:0] cnt [3] = '{16'h0, 16'h0, 16'h0};
   logic hready, d_cmp, d_cap, hresp;
   logic [15:0] b;
   logic [3:0] c;
   int failures = 0, n_tests = 0, pm [3], bm [3], nm = 0, nc = 0, m0 = 0;
   always #2.5 clk = ~clk;
   // count match and capture pulses
   always @(posedge clk) begin
      nm += $countones(match);
      nc += $countones(capt);
   end
   tbpio_top i_tbpio_top (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .STANDBY(stby), .CH1_COUNT(cnt[0]),
      .CH2_COUNT(cnt[1]), .CH3_COUNT(cnt[2]), .CH0_C_EVENT(c_ev), .CH_B_PIN_IN(pin_in),
      .CH_B_PIN_OUT(pin_out), .CH_B_PIN_OE(pin_oe), .CH_B_MATCH(match), .CH_B_CAPTURE(capt),
      .CH0_D_COMPARE_EN(d_cmp), .CH0_D_CAPTURE_EN(d_cap));
   tbpio_pins i_tbpio_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
      .pin_in(pin_in));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task results();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      results();
   end
   initial begin
      void'($urandom(17));
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      chk({29'h0, pin_out}, 32'h0);
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 8; k++) begin
            c = 4'(k);
            b = 16'($urandom);
            bm[i] = b;
            cnt[i] <= b ^ 16'h8000;
            bus(1'b1, tbpio_pkg::OFF_GRB_CH1 + 8'(4 * i), {16'h0, b});
            bus(1'b1, tbpio_pkg::OFF_IO_CH1 + 8'(4 * i), {24'h0, c, 4'h0});
            if (c[1:0] != 2'h0) pm[i] = c[2];
            repeat (2) @(posedge clk);
            chk({31'h0, pin_out[i]}, pm[i]);
            chk({31'h0, pin_oe[i]}, 32'h1);
            m0 = nm;
            cnt[i] <= b;
            @(posedge clk);
            cnt[i] <= b ^ 16'h8000;
            repeat (3) @(posedge clk);
            if (c[1:0] != 2'h0) pm[i] = (c[1:0] == 2'h1) ? 0 : (c[1:0] == 2'h2) ? 1 : 1 - pm[i];
            chk({31'h0, pin_out[i]}, pm[i]);
            chk(nm - m0, (c[1:0] != 2'h0) ? 1 : 0);
         end
         for (int k = 8; k < 16; k++) begin
            c = 4'(k);
            bus(1'b1, tbpio_pkg::OFF_IO_CH1 + 8'(4 * i), {24'h0, c, 4'h0});
            @(posedge clk);
            chk({31'h0, pin_oe[i]}, 32'h0);
            for (int s = 0; s < 3; s++) begin
               m0 = nc;
               b = 16'($urandom);
               cnt[i] <= b;
               if (s < 2) ext[i] <= (s == 0);
               else c_ev <= 1'b1;
               @(posedge clk);
               c_ev <= 1'b0;
               repeat (6) @(posedge clk);
               if ((i == 0 && c[2]) ? s == 2 : (s < 2 && (c[1] || c[0] == s[0]))) bm[i] = b;
               chk(nc - m0, (bm[i] == b) ? 1 : 0);
               bus(1'b0, tbpio_pkg::OFF_GRB_CH1 + 8'(4 * i), 32'h0);
               chk(r, {16'h0, bm[i]});
            end
         end
         bus(1'b1, tbpio_pkg::OFF_IO_CH1 + 8'(4 * i), 32'h0);
         $display("channel %0d output and capture done", i + 1);
      end
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, tbpio_pkg::OFF_CH0_MODE, {27'h0, k[0], 4'h0});
         bus(1'b1, tbpio_pkg::OFF_CH0_IO, {24'h0, k[1], 7'h0});
         @(posedge clk);
         chk({d_cmp, d_cap}, {!k[0] && !k[1], !k[0] && k[1]});
      end
      $display("buffer gating done");
      bus(1'b1, tbpio_pkg::OFF_IO_CH1 + 8'h4, 32'h60);
      repeat (4) @(posedge clk);
      bus(1'b0, tbpio_pkg::OFF_STATUS, 32'h0);
      chk(r, 32'h22);
      stby <= 1'b1;
      @(posedge clk);
      stby <= 1'b0;
      repeat (2) @(posedge clk);
      chk({29'h0, pin_out}, 32'h0);
      bus(1'b0, tbpio_pkg::OFF_IO_CH1 + 8'h4, 32'h0);
      chk(r, 32'h0);
      bus(1'b0, 8'h3c, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      $display("standby and unmapped done");
      results();
   end
endmodule : tb_timer_b_pin_io_control
